//--- core/sap_pkg.sv
// Shared constants and carrier types for the serial audio FIFO block
package sap_pkg;

	// ------------------------------------------------------------
	// FIFO geometry
	// ------------------------------------------------------------
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned DEPTH    = 16;
	localparam int unsigned PTR_W    = 4;
	localparam int unsigned CNT_W    = 5;
	localparam logic [4:0]  FULL_CNT = 5'h10;

	// ------------------------------------------------------------
	// Watermark codes and thresholds
	// ------------------------------------------------------------
	localparam logic [2:0] WM_ONE    = 3'h0;
	localparam logic [2:0] WM_FOUR   = 3'h4;
	localparam logic [2:0] WM_EIGHT  = 3'h5;
	localparam logic [2:0] WM_TWELVE = 3'h6;
	localparam logic [2:0] WM_ALL    = 3'h7;
	localparam logic [4:0] LVL_1     = 5'h01;
	localparam logic [4:0] LVL_4     = 5'h04;
	localparam logic [4:0] LVL_8     = 5'h08;
	localparam logic [4:0] LVL_12    = 5'h0C;
	localparam logic [4:0] LVL_16    = 5'h10;

	// ------------------------------------------------------------
	// Status and interrupt-enable bit positions
	// ------------------------------------------------------------
	localparam int unsigned ST_W        = 12;
	localparam int unsigned ST_TXREQ    = 0;
	localparam int unsigned ST_TXEMPTY  = 1;
	localparam int unsigned ST_RXREQ    = 2;
	localparam int unsigned ST_RXFULL   = 3;
	localparam int unsigned ST_TXCRDY   = 4;
	localparam int unsigned ST_RXCRDY   = 5;
	localparam int unsigned ST_TXUNDER  = 6;
	localparam int unsigned ST_TXOVER   = 7;
	localparam int unsigned ST_RXOVER   = 8;
	localparam int unsigned ST_RXUNDER  = 9;
	localparam int unsigned ST_FRAME_SYNC_ERROR_FLAG    = 10;
	localparam int unsigned ST_SLOT_ASSIGN_ERROR_FLAG    = 11;
	localparam logic [11:0] ST_RESET    = 12'h000;
	localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

	// Status word and a data word with its valid tag
	typedef logic [ST_W-1:0] status_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} word_t;

	// Skid buffer state
	typedef enum logic [1:0] {
		SK_EMPTY,
		SK_ONE,
		SK_TWO
	} skid_state_t;

endpackage

//--- core/skid_buffer.sv
// Two-entry valid/ready buffer for one data stream
`timescale 1ns/1ns
module skid_buffer
	import sap_pkg::*;
(
	input  wire logic                       sys_clk,
	input  wire logic                       rst_b,
	input  wire logic                       flush,
	input  wire logic                       inValid,
	output logic                            inReady,
	input  wire logic [sap_pkg::DATA_W-1:0] inData,
	output logic                            outValid,
	input  wire logic                       outReady,
	output logic      [sap_pkg::DATA_W-1:0] outData
);
	import sap_pkg::*;

	skid_state_t       state_r;
	skid_state_t       state_nxt;
	logic [DATA_W-1:0] head_r;
	logic [DATA_W-1:0] tail_r;
	logic              push;
	logic              pop;

	// ------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------
	assign inReady  = (state_r != SK_TWO);
	assign outValid = (state_r != SK_EMPTY);
	assign outData  = head_r;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Occupancy step
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SK_EMPTY: state_nxt = push ? SK_ONE : SK_EMPTY;
			SK_ONE: begin
				if (push && !pop)
					state_nxt = SK_TWO;
				else if (pop && !push)
					state_nxt = SK_EMPTY;
			end
			SK_TWO:   state_nxt = pop ? SK_ONE : SK_TWO;
			default:  state_nxt = SK_EMPTY;
		endcase
	end

	// State, flushed by the soft reset of the owning unit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			state_r <= SK_EMPTY;
		else if (flush)
			state_r <= SK_EMPTY;
		else
			state_r <= state_nxt;
	end

	// Head holds the oldest word, tail the overflow slot
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			head_r <= DATA_RESET;
			tail_r <= DATA_RESET;
		end else begin
			if (push && ((state_r == SK_EMPTY) || (state_r == SK_ONE && pop)))
				head_r <= inData;
			else if (pop && state_r == SK_TWO)
				head_r <= tail_r;
			if (push && ((state_r == SK_ONE && !pop) || state_r == SK_TWO))
				tail_r <= inData;
		end
	end

endmodule

//--- core/serial_audio_fifo_irq.sv
// Transmit/receive FIFOs, watermarks, soft resets and status of the serial audio port
`timescale 1ns/1ns

module serial_audio_fifo_irq
	import sap_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_b,
	input  wire logic                      moduleStop,
	input  wire logic                      txSoftReset,
	input  wire logic                      rxSoftReset,
	input  wire logic                      txEnableSet,
	input  wire logic                      rxEnableSet,
	output logic                           txEnableBit,
	output logic                           rxEnableBit,
	input  wire logic [2:0]                txWatermarkCode,
	input  wire logic [2:0]                rxWatermarkCode,
	input  wire logic                      busWrite,
	input  wire logic [sap_pkg::DATA_W-1:0] busWdata,
	input  wire logic                      busRead,
	output logic      [sap_pkg::DATA_W-1:0] rxDataRegister,
	output logic      [sap_pkg::CNT_W-1:0] txEmptyCount,
	output logic      [sap_pkg::CNT_W-1:0] rxValidCount,
	input  wire logic                      txSlotTick,
	output logic                           serTxValid,
	input  wire logic                      serTxReady,
	output logic      [sap_pkg::DATA_W-1:0] serTxData,
	input  wire logic                      serRxValid,
	input  wire logic [sap_pkg::DATA_W-1:0] serRxData,
	input  wire logic                      slaveMode,
	input  wire logic                      frameSyncSignal,
	input  wire logic [7:0]                frameBits,
	input  wire logic                      slotAssignClash,
	input  wire logic                      txControlWritable,
	input  wire logic                      rxControlValid,
	input  wire logic                      dmaTxEnable,
	input  wire logic                      dmaRxEnable,
	input  wire logic                      dmaTxEnd,
	input  wire logic                      dmaRxEnd,
	input  wire logic                      errorClear,
	input  wire logic [sap_pkg::ST_W-1:0]  irqEnableRegister,
	output logic      [sap_pkg::ST_W-1:0]  portStatusRegister,
	output logic                           txTransferRequest,
	output logic                           rxTransferRequest,
	output logic                           dmaTxRequest,
	output logic                           dmaRxRequest,
	output logic                           irq
);
	import sap_pkg::*;

	// ------------------------------------------------------------
	// Synchroniser for the pin-level frame sync input
	// ------------------------------------------------------------
	logic [1:0] fsSync_r;
	logic       fsPrev_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fsSync_r <= 2'h0;
			fsPrev_r <= 1'b0;
		end else begin
			fsSync_r <= {fsSync_r[0], frameSyncSignal};
			fsPrev_r <= fsSync_r[1];
		end
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] txMem [DEPTH];
	logic [DATA_W-1:0] rxMem [DEPTH];
	logic [PTR_W-1:0]  txWp_r;
	logic [PTR_W-1:0]  txRp_r;
	logic [PTR_W-1:0]  rxWp_r;
	logic [PTR_W-1:0]  rxRp_r;
	logic [CNT_W-1:0]  txCnt_r;
	logic [CNT_W-1:0]  rxCnt_r;
	logic [DATA_W-1:0] lastTx_r;
	logic              txEn_r;
	logic              rxEn_r;
	logic [7:0]        bitCnt_r;
	logic              frameSeen_r;
	logic [CNT_W-1:0]  txFree_r;
	status_t           err_r;
	word_t             txWord;
	logic              bufInReady;
	logic              bufOutValid;
	logic [DATA_W-1:0] bufOutData;

	// ------------------------------------------------------------
	// Activity decode
	// ------------------------------------------------------------
	wire run       = !moduleStop;
	wire txFull    = (txCnt_r == FULL_CNT);
	wire txEmpty   = (txCnt_r == 5'h00);
	wire rxFull    = (rxCnt_r == FULL_CNT);
	wire rxEmpty   = (rxCnt_r == 5'h00);
	wire txPush    = run && busWrite && !txFull && !txSoftReset;
	wire txOverEv  = run && busWrite && txFull;
	wire txPop     = run && txEn_r && !txEmpty && bufInReady && !txSoftReset;
	wire txUnderEv = run && txEn_r && txSlotTick && txEmpty && !bufOutValid;
	wire rxPush    = run && rxEn_r && serRxValid && !rxFull && !rxSoftReset;
	wire rxOverEv  = run && rxEn_r && serRxValid && rxFull;
	wire rxPop     = run && busRead && !rxEmpty && !rxSoftReset;
	wire rxUnderEv = run && busRead && rxEmpty;
	wire fsEdge    = fsSync_r[1] && !fsPrev_r;
	wire earlySync = frameSeen_r && (bitCnt_r < frameBits);
	wire fsErrEv   = run && slaveMode && fsEdge && earlySync;
	wire saErrEv   = run && slotAssignClash;

	// Word offered to the two-entry buffer: FIFO head at the read pointer
	assign txWord.valid = txPop;
	assign txWord.data  = txMem[txRp_r];

	// ------------------------------------------------------------
	// Two-entry buffer toward the serialiser
	// ------------------------------------------------------------
	skid_buffer u_txBuf (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.flush    (txSoftReset),
		.inValid  (txWord.valid),
		.inReady  (bufInReady),
		.inData   (txWord.data),
		.outValid (bufOutValid),
		.outReady (serTxReady && run),
		.outData  (bufOutData)
	);

	// Underflow repeats the previously sent word
	assign serTxValid = (bufOutValid || (txUnderEv && txEn_r)) && run;
	assign serTxData  = bufOutValid ? bufOutData : lastTx_r;

	// ------------------------------------------------------------
	// Transmit pointers, count and memory
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txWp_r  <= 4'h0;
			txRp_r  <= 4'h0;
			txCnt_r <= 5'h00;
		end else if (txSoftReset) begin
			txWp_r  <= 4'h0;
			txRp_r  <= 4'h0;
			txCnt_r <= 5'h00;
		end else begin
			if (txPush)
				txWp_r <= txWp_r + 4'h1;
			if (txPop)
				txRp_r <= txRp_r + 4'h1;
			txCnt_r <= txCnt_r + {4'h0, txPush} - {4'h0, txPop};
		end
	end

	// Free-entry count in its own register, so the reported level is a flop
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			txFree_r <= FULL_CNT;
		else if (txSoftReset)
			txFree_r <= FULL_CNT;
		else
			txFree_r <= txFree_r - {4'h0, txPush} + {4'h0, txPop};
	end

	// Memory write, ignored when full
	always_ff @(posedge sys_clk) begin
		if (txPush)
			txMem[txWp_r] <= busWdata;
	end

	// Last word handed to the serialiser, cleared by the transmit soft reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			lastTx_r <= DATA_RESET;
		else if (txSoftReset)
			lastTx_r <= DATA_RESET;
		else if (bufOutValid && serTxReady && run)
			lastTx_r <= bufOutData;
	end

	// ------------------------------------------------------------
	// Receive pointers, count and memory
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxWp_r  <= 4'h0;
			rxRp_r  <= 4'h0;
			rxCnt_r <= 5'h00;
		end else if (rxSoftReset) begin
			rxWp_r  <= 4'h0;
			rxRp_r  <= 4'h0;
			rxCnt_r <= 5'h00;
		end else begin
			if (rxPush)
				rxWp_r <= rxWp_r + 4'h1;
			if (rxPop)
				rxRp_r <= rxRp_r + 4'h1;
			rxCnt_r <= rxCnt_r + {4'h0, rxPush} - {4'h0, rxPop};
		end
	end

	// Memory write, dropped when full
	always_ff @(posedge sys_clk) begin
		if (rxPush)
			rxMem[rxWp_r] <= serRxData;
	end

	// Read data register; keeps old value on an empty read
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rxDataRegister <= DATA_RESET;
		else if (rxSoftReset)
			rxDataRegister <= DATA_RESET;
		else if (rxPop)
			rxDataRegister <= rxMem[rxRp_r];
	end

	// ------------------------------------------------------------
	// Enable bits
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txEn_r <= 1'b0;
			rxEn_r <= 1'b0;
		end else begin
			if (txSoftReset)
				txEn_r <= 1'b0;
			else if (txEnableSet)
				txEn_r <= 1'b1;
			if (rxSoftReset)
				rxEn_r <= 1'b0;
			else if (rxEnableSet)
				rxEn_r <= 1'b1;
		end
	end
	assign txEnableBit = txEn_r;
	assign rxEnableBit = rxEn_r;

	// ------------------------------------------------------------
	// Frame bit counter, restarted by every sync seen while the module is not stopped
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			bitCnt_r <= 8'h00;
		else if (run && fsEdge)
			bitCnt_r <= 8'h01;
		else if (run && txSlotTick && bitCnt_r != 8'hFF)
			bitCnt_r <= bitCnt_r + 8'h01;
	end

	// No frame runs before the first sync, so that one cannot be early
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			frameSeen_r <= 1'b0;
		else if (run && fsEdge)
			frameSeen_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// Levels and watermark requests
	// ------------------------------------------------------------
	assign txEmptyCount = txFree_r;
	assign rxValidCount = rxCnt_r;

	// Transmit request from free space; reserved codes give no request
	always_comb begin
		case (txWatermarkCode)
			WM_ONE:    txTransferRequest = (txFree_r >= LVL_16);
			WM_FOUR:   txTransferRequest = (txFree_r >= LVL_12);
			WM_EIGHT:  txTransferRequest = (txFree_r >= LVL_8);
			WM_TWELVE: txTransferRequest = (txFree_r >= LVL_4);
			WM_ALL:    txTransferRequest = (txFree_r >= LVL_1);
			default:   txTransferRequest = 1'b0;
		endcase
	end

	// Receive request from valid entries
	always_comb begin
		case (rxWatermarkCode)
			WM_ONE:    rxTransferRequest = (rxCnt_r >= LVL_1);
			WM_FOUR:   rxTransferRequest = (rxCnt_r >= LVL_4);
			WM_EIGHT:  rxTransferRequest = (rxCnt_r >= LVL_8);
			WM_TWELVE: rxTransferRequest = (rxCnt_r >= LVL_12);
			WM_ALL:    rxTransferRequest = (rxCnt_r >= LVL_16);
			default:   rxTransferRequest = 1'b0;
		endcase
	end

	// DMA requests drop for the end-of-transfer cycle
	assign dmaTxRequest = dmaTxEnable && txTransferRequest && !dmaTxEnd;
	assign dmaRxRequest = dmaRxEnable && rxTransferRequest && !dmaRxEnd;

	// ------------------------------------------------------------
	// Sticky error flags; a new event beats the clear
	// ------------------------------------------------------------
	status_t errSet;
	always_comb begin
		errSet             = ST_RESET;
		errSet[ST_TXUNDER] = txUnderEv;
		errSet[ST_TXOVER]  = txOverEv;
		errSet[ST_RXOVER]  = rxOverEv;
		errSet[ST_RXUNDER] = rxUnderEv;
		errSet[ST_FRAME_SYNC_ERROR_FLAG]   = fsErrEv;
		errSet[ST_SLOT_ASSIGN_ERROR_FLAG]   = saErrEv;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			err_r <= ST_RESET;
		else if (errorClear)
			err_r <= errSet;
		else
			err_r <= err_r | errSet;
	end

	// ------------------------------------------------------------
	// Status word and interrupt
	// ------------------------------------------------------------
	always_comb begin
		portStatusRegister             = err_r;
		portStatusRegister[ST_TXREQ]   = txTransferRequest && !txSoftReset;
		portStatusRegister[ST_TXEMPTY] = txEmpty && !txSoftReset;
		portStatusRegister[ST_RXREQ]   = rxTransferRequest && !rxSoftReset;
		portStatusRegister[ST_RXFULL]  = rxFull && !rxSoftReset;
		portStatusRegister[ST_TXCRDY]  = txControlWritable && !txSoftReset;
		portStatusRegister[ST_RXCRDY]  = rxControlValid && !rxSoftReset;
	end

	assign irq = |(portStatusRegister & irqEnableRegister);

endmodule

//--- bench/sap_exp.svh
// Expected transfer request for a watermark code and a fill level
`ifndef SAP_EXP_SVH
`define SAP_EXP_SVH
function automatic logic wmExp(logic [2:0] c, logic [4:0] n, logic tx);
	case (c)
		3'h0: return tx ? n == 5'h10 : n >= 5'h01;
		3'h4: return n >= (tx ? 5'h0C : 5'h04);
		3'h5: return n >= 5'h08;
		3'h6: return n >= (tx ? 5'h04 : 5'h0C);
		3'h7: return tx ? n >= 5'h01 : n == 5'h10;
		default: return 1'h0;
	endcase
endfunction
`endif

//--- bench/sap_checker.sv
// Port-level concurrent checks of the serial audio FIFO block
`timescale 1ns/1ns
`include "sap_exp.svh"
module sap_checker
	import sap_pkg::*;
(
	input logic              sys_clk,
	input logic              rst_b,
	input logic              moduleStop,
	input logic              txSoftReset,
	input logic              rxSoftReset,
	input logic              busWrite,
	input logic              busRead,
	input logic              dmaTxEnable,
	input logic              dmaTxEnd,
	input logic              txEnableBit,
	input logic              rxEnableBit,
	input logic              txTransferRequest,
	input logic              rxTransferRequest,
	input logic              dmaTxRequest,
	input logic              irq,
	input logic [2:0]        txWatermarkCode,
	input logic [2:0]        rxWatermarkCode,
	input logic [CNT_W-1:0]  txEmptyCount,
	input logic [CNT_W-1:0]  rxValidCount,
	input logic [DATA_W-1:0] rxDataRegister,
	input logic [ST_W-1:0]   irqEnableRegister,
	input logic [ST_W-1:0]   portStatusRegister
);
	// One clock domain, one reset
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// Requests, interrupt and error flags
	// ------------------------------------------------------------
	chk_tx_req_code: assert property (!txSoftReset |->
		txTransferRequest == wmExp(txWatermarkCode, txEmptyCount, 1'h1)) else $error("tx request");
	chk_rx_req_code: assert property (!rxSoftReset |->
		rxTransferRequest == wmExp(rxWatermarkCode, rxValidCount, 1'h0)) else $error("rx request");
	chk_irq_combine: assert property (irq == |(irqEnableRegister & portStatusRegister))
		else $error("irq combine");
	chk_tx_over_set: assert property (busWrite && txEmptyCount == 5'h00 && !moduleStop
		&& !txSoftReset |=> portStatusRegister[ST_TXOVER]) else $error("tx overflow");
	chk_rx_under_set: assert property (busRead && rxValidCount == 5'h00 && !moduleStop
		&& !rxSoftReset |=> portStatusRegister[ST_RXUNDER] && $stable(rxDataRegister))
		else $error("rx underflow");
	chk_dma_end_low: assert property (dmaTxRequest == (dmaTxEnable && txTransferRequest
		&& !dmaTxEnd)) else $error("dma request");

	// ------------------------------------------------------------
	// Soft resets and module stop
	// ------------------------------------------------------------
	chk_tx_soft_reset: assert property (txSoftReset |-> !portStatusRegister[ST_TXREQ]
		&& !portStatusRegister[ST_TXEMPTY] ##1 txEmptyCount == FULL_CNT && !txEnableBit)
		else $error("tx reset");
	chk_rx_soft_reset: assert property (rxSoftReset |=> rxValidCount == 5'h00
		&& !rxEnableBit && rxDataRegister == DATA_RESET) else $error("rx reset");
	chk_stop_hold: assert property (moduleStop && !txSoftReset && !rxSoftReset |=>
		$stable(txEmptyCount) && $stable(rxValidCount) && $stable(rxDataRegister))
		else $error("stop hold");
endmodule

bind serial_audio_fifo_irq sap_checker u_chk (.*);

//--- bench/ser_sink.sv
// Receiver model for the serial transmit stream, with random stalls
`timescale 1ns/1ns
module ser_sink
	import sap_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              stallOn,
	input  wire logic              serTxValid,
	output logic                   serTxReady,
	input  wire logic [DATA_W-1:0] serTxData
);
	int                seed = 36588;
	logic [DATA_W-1:0] got[$];

	// Takes one whole word per handshake, ready changes just after edges
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			serTxReady <= 1'h0;
		end else begin
			if (serTxValid && serTxReady) got.push_back(serTxData);
			serTxReady <= !stallOn || $random(seed) % 2;
		end
	end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the serial audio FIFO block
`timescale 1ns/1ns
`include "sap_exp.svh"
module testbench;
	import sap_pkg::*;
	// ------------------------------------------------------------
	// Signals, all inputs set at time zero
	// ------------------------------------------------------------
	logic              sys_clk = 1'h0, rst_b = 1'h0, moduleStop = 1'h0, stallOn = 1'h1;
	logic              txSoftReset = 1'h0, rxSoftReset = 1'h0, txEnableSet = 1'h0;
	logic              rxEnableSet = 1'h0, busWrite = 1'h0, busRead = 1'h0, txSlotTick = 1'h0;
	logic              serRxValid = 1'h0, slaveMode = 1'h0, frameSyncSignal = 1'h0;
	logic              slotAssignClash = 1'h0, txControlWritable = 1'h0, rxControlValid = 1'h0;
	logic              dmaTxEnable = 1'h0, dmaRxEnable = 1'h0, dmaTxEnd = 1'h0;
	logic              dmaRxEnd = 1'h0, errorClear = 1'h0;
	logic [2:0]        txWatermarkCode = 3'h0, rxWatermarkCode = 3'h0;
	logic [7:0]        frameBits = 8'h08;
	logic [ST_W-1:0]   irqEnableRegister = 12'h000, portStatusRegister;
	logic [DATA_W-1:0] busWdata = 32'h0, serRxData = 32'h0, rxDataRegister, serTxData;
	logic [CNT_W-1:0]  txEmptyCount, rxValidCount;
	logic              txEnableBit, rxEnableBit, serTxValid, serTxReady, irq;
	logic              txTransferRequest, rxTransferRequest, dmaTxRequest, dmaRxRequest;
	int                seed = 36588, n_mismatch = 0, samples_checked = 0, i, k;
	logic [DATA_W-1:0] txQ[$], rxQ[$];
	logic [2:0]        codes[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};

	always #50 sys_clk = ~sys_clk;
	serial_audio_fifo_irq u_dut (.*);
	ser_sink u_sink (.*);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic tick(int n = 1);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		tick();
		s = 1'h0;
	endtask
	// Every listed watermark code against the present fill level
	task automatic sweep(logic tx);
		for (k = 0; k < 5; k++) begin
			if (tx) txWatermarkCode = codes[k];
			else rxWatermarkCode = codes[k];
			#1;
			if (tx) chk("txreq", txTransferRequest, wmExp(codes[k], txEmptyCount, 1'h1));
			else chk("rxreq", rxTransferRequest, wmExp(codes[k], rxValidCount, 1'h0));
		end
	endtask

	// Watchdog
	initial begin
		tick(3000);
		n_mismatch++;
		finish_test;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		tick(16);
		rst_b = 1'h1;
		chk("errs", portStatusRegister[11:6], 0);
		// Back-to-back writes, one past full
		busWrite = 1'h1;
		for (i = 0; i < 17; i++) begin
			busWdata = $random(seed);
			if (i < 16) txQ.push_back(busWdata);
			chk("txcnt", txEmptyCount, 16 - i);
			sweep(1'h1);
			tick();
		end
		busWrite = 1'h0;
		chk("txover", portStatusRegister[ST_TXOVER], 1);
		chk("txcnt", txEmptyCount, 0);
		// Drain through a stalling receiver, then starve the slot
		pulse(txEnableSet);
		for (i = 0; i < 400 && u_sink.got.size() < 16; i++) tick();
		for (i = 0; i < 16; i++) chk("txdata", u_sink.got[i], txQ[i]);
		chk("txempty", portStatusRegister[ST_TXEMPTY], 1);
		stallOn = 1'h0;
		tick(2);
		pulse(txSlotTick);
		tick(3);
		chk("txunder", portStatusRegister[ST_TXUNDER], 1);
		chk("resend", u_sink.got[16], txQ[15]);
		irqEnableRegister = 12'h002;
		#1;
		chk("irq", irq, 1);
		pulse(errorClear);
		chk("errs", portStatusRegister[11:6], 0);
		irqEnableRegister = 12'h0C0;
		#1;
		chk("irq", irq, 0);
		// DMA request drops in the end cycle only
		dmaTxEnable = 1'h1;
		#1;
		chk("dmareq", dmaTxRequest, 1);
		dmaTxEnd = 1'h1;
		#1;
		chk("dmareq", dmaTxRequest, 0);
		tick();
		dmaTxEnd = 1'h0;
		#1;
		chk("dmareq", dmaTxRequest, 1);
		// Receive one past full
		pulse(rxEnableSet);
		serRxValid = 1'h1;
		for (i = 0; i < 17; i++) begin
			serRxData = $random(seed);
			if (i < 16) rxQ.push_back(serRxData);
			chk("rxcnt", rxValidCount, i);
			sweep(1'h0);
			tick();
		end
		serRxValid = 1'h0;
		chk("rxover", portStatusRegister[ST_RXOVER], 1);
		chk("rxfull", portStatusRegister[ST_RXFULL], 1);
		// Receive DMA request drops in the end cycle only
		dmaRxEnable = 1'h1;
		dmaRxEnd = 1'h1;
		#1;
		chk("dmarx", dmaRxRequest, 0);
		tick();
		dmaRxEnd = 1'h0;
		#1;
		chk("dmarx", dmaRxRequest, 1);
		moduleStop = 1'h1;
		pulse(busRead);
		chk("rxcnt", rxValidCount, 16);
		moduleStop = 1'h0;
		tick();
		// Back-to-back reads, one past empty
		busRead = 1'h1;
		for (i = 0; i < 16; i++) begin
			tick();
			chk("rxdata", rxDataRegister, rxQ[i]);
		end
		tick();
		busRead = 1'h0;
		chk("rxunder", portStatusRegister[ST_RXUNDER], 1);
		chk("rxdata", rxDataRegister, rxQ[15]);
		// Slot clash, control sources, early frame syncs
		slotAssignClash = 1'h1;
		txControlWritable = 1'h1;
		rxControlValid = 1'h1;
		slaveMode = 1'h1;
		tick();
		slotAssignClash = 1'h0;
		chk("slot_assign_error_flag", portStatusRegister[ST_SLOT_ASSIGN_ERROR_FLAG], 1);
		chk("crdy", portStatusRegister[5:4], 3);
		for (i = 0; i < 2; i++) begin
			frameSyncSignal = 1'h1;
			tick(2);
			frameSyncSignal = 1'h0;
			tick(4);
		end
		chk("frame_sync_error_flag", portStatusRegister[ST_FRAME_SYNC_ERROR_FLAG], 1);
		// Both soft resets with words held
		serRxValid = 1'h1;
		tick(2);
		serRxValid = 1'h0;
		chk("rxcnt", rxValidCount, 2);
		// Hold three tx words, enable set just before the reset edge
		pulse(txSoftReset);
		busWrite = 1'h1;
		tick(3);
		busWrite = 1'h0;
		pulse(txEnableSet);
		chk("txcnt", txEmptyCount, 13);
		chk("txen", txEnableBit, 1);
		rxSoftReset = 1'h1;
		txSoftReset = 1'h1;
		tick();
		rxSoftReset = 1'h0;
		txSoftReset = 1'h0;
		chk("rxcnt", rxValidCount, 0);
		chk("rxdat", rxDataRegister, 0);
		chk("enables", {txEnableBit, rxEnableBit}, 0);
		chk("txcnt", txEmptyCount, 16);
		finish_test;
	end
endmodule
